// >>> rtl/mem_space_decoder.sv
// Data and program memory space decoder with reset state
`timescale 1ns/1ps
`default_nettype none
`include "mem_space_params.svh"
module mem_space_decoder
    import mem_space_pkg::*;
(
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Variant strap
    input  wire variant_t    variant_i,
    // Data access from the core
    input  wire data_req_t   req_i,
    input  wire logic [7:0]  rdata_i,
    // Program flow from the core
    input  wire logic        pc_load_i,
    input  wire logic [16:0] pc_target_i,
    input  wire logic        pc_step_i,
    input  wire logic        pc_step2_i,
    input  wire logic        push_ret_i,
    // Flash write request and locks
    input  wire logic        flash_wr_i,
    input  wire logic [16:0] flash_addr_i,
    input  wire sec_lock_t   app_lock_i,
    input  wire sec_lock_t   tbl_lock_i,
    input  wire sec_lock_t   boot_lock_i,
    // Data side outputs
    output data_rgn_t        region_o,
    output logic             io_sel_o,
    output logic             ee_sel_o,
    output logic             sram_sel_o,
    output logic             wr_en_o,
    output logic             rd_en_o,
    output logic             op_illegal_o,
    output logic [7:0]       rdata_o,
    output logic             skip_o,
    // Program side outputs
    output logic [16:0]      program_counter_o,
    output flash_sec_t       fetch_sec_o,
    output logic             fetch_ok_o,
    output logic             flash_wr_en_o,
    output logic [15:0]      stack_pointer_o
);
    // ------------------------------------------------------------
    // Decode functions
    // ------------------------------------------------------------
    function automatic data_rgn_t data_region(input logic [15:0] a, input variant_t v);
        logic [15:0] ee_end;
        logic [15:0] sr_end;
        ee_end = (v == VAR_64K || v == VAR_128K) ? `EE_END_2K : `EE_END_1K;
        sr_end = (v == VAR_128K) ? `SRAM_END_8K :
                 (v == VAR_16K)  ? `SRAM_END_2K : `SRAM_END_4K;
        if (a <= `IO_END)
            data_region = RGN_IO;
        else if (a <= ee_end)
            data_region = RGN_EE;
        else if (a >= `SRAM_BASE && a <= sr_end)
            data_region = RGN_SRAM;
        else
            data_region = RGN_RSVD;
    endfunction

    function automatic flash_sec_t flash_section(input logic [16:0] w, input variant_t v);
        logic [16:0] tb;
        logic [16:0] bb;
        logic [16:0] be;
        unique case (v)
            VAR_128K: begin tb = `TBL_BASE_128; bb = `BOOT_BASE_128; be = `BOOT_END_128; end
            VAR_64K:  begin tb = `TBL_BASE_64;  bb = `BOOT_BASE_64;  be = `BOOT_END_64;  end
            VAR_32K:  begin tb = `TBL_BASE_32;  bb = `BOOT_BASE_32;  be = `BOOT_END_32;  end
            VAR_16K:  begin tb = `TBL_BASE_16;  bb = `BOOT_BASE_16;  be = `BOOT_END_16;  end
        endcase
        if (w < tb)
            flash_section = SEC_APP;
        else if (w < bb)
            flash_section = SEC_TABLE;
        else if (w <= be)
            flash_section = SEC_BOOT;
        else
            flash_section = SEC_NONE;
    endfunction

    function automatic sec_lock_t lock_of(input flash_sec_t s, input sec_lock_t a,
                                          input sec_lock_t t, input sec_lock_t b);
        unique case (s)
            SEC_APP:   lock_of = a;
            SEC_TABLE: lock_of = t;
            SEC_BOOT:  lock_of = b;
            SEC_NONE:  lock_of = '{wr_lock: 2'b11, rd_lock: 2'b11};
        endcase
    endfunction

    // ------------------------------------------------------------
    // Strap capture and data decode
    // ------------------------------------------------------------
    variant_t  variant_r;
    data_rgn_t rgn;
    logic      is_io;
    logic      port_ok;
    logic      bit_ok;
    logic      is_wr;
    logic      is_rd;
    logic      legal;

    // Strap pin passes two flops; no reset, so the value has settled by the
    // end of the reset pulse and the stack top loads the right size at release
    variant_t  variant_meta_r;
    always_ff @(posedge clk_i)
    begin
        variant_meta_r <= variant_i;
        variant_r      <= variant_meta_r;
    end

    always_comb
    begin
        rgn     = data_region(req_i.addr, variant_r);
        is_io   = (rgn == RGN_IO);
        port_ok = req_i.addr <= `PORT_IO_END;
        bit_ok  = req_i.addr <= `BIT_IO_END;
        unique case (req_i.op)
            OP_MEM_READ, OP_MEM_WRITE: legal = 1'b1;
            OP_PORT_READ, OP_PORT_WRITE: legal = port_ok;
            OP_BIT_SET, OP_BIT_CLEAR, OP_BIT_TEST: legal = bit_ok;
            OP_NONE: legal = 1'b0;
        endcase
        is_wr = legal && (req_i.op == OP_MEM_WRITE || req_i.op == OP_PORT_WRITE ||
                          req_i.op == OP_BIT_SET || req_i.op == OP_BIT_CLEAR);
        is_rd = legal && (req_i.op == OP_MEM_READ || req_i.op == OP_PORT_READ ||
                          req_i.op == OP_BIT_TEST || req_i.op == OP_BIT_SET ||
                          req_i.op == OP_BIT_CLEAR);
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            region_o     <= RGN_RSVD;
            io_sel_o     <= 1'b0;
            ee_sel_o     <= 1'b0;
            sram_sel_o   <= 1'b0;
            wr_en_o      <= 1'b0;
            rd_en_o      <= 1'b0;
            op_illegal_o <= 1'b0;
        end
        else
        begin
            region_o     <= rgn;
            io_sel_o     <= legal && is_io;
            ee_sel_o     <= legal && rgn == RGN_EE;
            sram_sel_o   <= legal && rgn == RGN_SRAM;
            wr_en_o      <= is_wr && rgn != RGN_RSVD;
            rd_en_o      <= is_rd && rgn != RGN_RSVD;
            op_illegal_o <= req_i.op != OP_NONE && !legal;
        end
    end

    // Read data return, taken while the read strobe stands; reserved reads as zero
    logic [2:0] bit_prev_r;
    data_op_t   op_prev_r;
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            bit_prev_r <= 3'h0;
            op_prev_r  <= OP_NONE;
            rdata_o    <= 8'h00;
            skip_o     <= 1'b0;
        end
        else
        begin
            bit_prev_r <= req_i.bit_sel;
            op_prev_r  <= req_i.op;
            rdata_o    <= rd_en_o ? rdata_i : 8'h00;
            skip_o     <= rd_en_o && op_prev_r == OP_BIT_TEST &&
                          rdata_i[bit_prev_r] == 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Program counter, fetch and flash write gating
    // ------------------------------------------------------------
    flash_sec_t pc_sec;
    flash_sec_t wr_sec;
    sec_lock_t  wr_lock;
    sec_lock_t  pc_lock;
    assign pc_sec  = flash_section(program_counter_o, variant_r);
    assign pc_lock = lock_of(pc_sec, app_lock_i, tbl_lock_i, boot_lock_i);
    assign wr_sec  = flash_section(flash_addr_i, variant_r);
    assign wr_lock = lock_of(wr_sec, app_lock_i, tbl_lock_i, boot_lock_i);

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            program_counter_o <= `PC_RESET;
        else if (pc_load_i)
            program_counter_o <= pc_target_i;
        else if (pc_step2_i)
            program_counter_o <= program_counter_o + 17'h00002;
        else if (pc_step_i)
            program_counter_o <= program_counter_o + 17'h00001;
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            fetch_sec_o   <= SEC_APP;
            fetch_ok_o    <= 1'b0;
            flash_wr_en_o <= 1'b0;
        end
        else
        begin
            fetch_sec_o   <= pc_sec;
            fetch_ok_o    <= pc_sec != SEC_NONE && pc_lock.rd_lock != 2'b00;
            flash_wr_en_o <= flash_wr_i && pc_sec == SEC_BOOT &&
                             wr_sec != SEC_NONE && wr_lock.wr_lock == 2'b11;
        end
    end

    // ------------------------------------------------------------
    // Stack pointer
    // ------------------------------------------------------------
    logic [15:0] sram_top;
    logic        sp_wr_lo;
    logic        sp_wr_hi;
    always_comb
    begin
        unique case (variant_r)
            VAR_128K: sram_top = `SRAM_END_8K;
            VAR_16K:  sram_top = `SRAM_END_2K;
            default:  sram_top = `SRAM_END_4K;
        endcase
        sp_wr_lo = is_wr && req_i.addr == `SP_LO_ADDR;
        sp_wr_hi = is_wr && req_i.addr == `SP_HI_ADDR;
    end

    logic [15:0] sp_val;
    stack_ptr_reg u_sp (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .top_i   (sram_top),
        .wr_lo_i (sp_wr_lo),
        .wr_hi_i (sp_wr_hi),
        .wdata_i (req_i.wdata),
        .push_i  (push_ret_i),
        .sp_o    (sp_val)
    );

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            stack_pointer_o <= 16'h0000;
        else
            stack_pointer_o <= sp_val;
    end
endmodule // mem_space_decoder
`default_nettype wire

// >>> rtl/mem_space_params.svh
// Address map constants for the memory space decoder
`ifndef MEM_SPACE_PARAMS_SVH
`define MEM_SPACE_PARAMS_SVH
`define IO_END          16'h0fff
`define EE_BASE         16'h1000
`define EE_END_2K       16'h17ff
`define EE_END_1K       16'h13ff
`define SRAM_BASE       16'h2000
`define SRAM_END_8K     16'h3fff
`define SRAM_END_4K     16'h2fff
`define SRAM_END_2K     16'h27ff
`define PORT_IO_END     16'h003f
`define BIT_IO_END      16'h001f
`define SP_LO_ADDR      16'h003d
`define SP_HI_ADDR      16'h003e
`define APP_END_128     17'h0efff
`define TBL_BASE_128    17'h0f000
`define BOOT_BASE_128   17'h10000
`define BOOT_END_128    17'h10fff
`define TBL_BASE_64     17'h07800
`define BOOT_BASE_64    17'h08000
`define BOOT_END_64     17'h087ff
`define TBL_BASE_32     17'h03800
`define BOOT_BASE_32    17'h04000
`define BOOT_END_32     17'h047ff
`define TBL_BASE_16     17'h01800
`define BOOT_BASE_16    17'h02000
`define BOOT_END_16     17'h027ff
`define PC_RESET        17'h00000
`endif

// >>> rtl/mem_space_pkg.sv
// Types shared by the memory space decoder
package mem_space_pkg;
    typedef enum logic [1:0] {VAR_16K, VAR_32K, VAR_64K, VAR_128K} variant_t;
    typedef enum logic [2:0] {RGN_IO, RGN_EE, RGN_SRAM, RGN_RSVD} data_rgn_t;
    typedef enum logic [1:0] {SEC_APP, SEC_TABLE, SEC_BOOT, SEC_NONE} flash_sec_t;
    typedef enum logic [2:0] {
        OP_NONE, OP_MEM_READ, OP_MEM_WRITE, OP_PORT_READ, OP_PORT_WRITE,
        OP_BIT_SET, OP_BIT_CLEAR, OP_BIT_TEST
    } data_op_t;
    typedef struct packed {
        data_op_t    op;
        logic [15:0] addr;
        logic [7:0]  wdata;
        logic [2:0]  bit_sel;
    } data_req_t;
    typedef struct packed {
        logic [1:0] wr_lock;
        logic [1:0] rd_lock;
    } sec_lock_t;
endpackage

// >>> rtl/stack_ptr_reg.sv
// Stack pointer register, cleared under reset and loaded with top of SRAM on the first edge after release
`timescale 1ns/1ps
`default_nettype none
module stack_ptr_reg
    import mem_space_pkg::*;
(
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Reset value and update
    input  wire logic [15:0] top_i,
    input  wire logic        wr_lo_i,
    input  wire logic        wr_hi_i,
    input  wire logic [7:0]  wdata_i,
    input  wire logic        push_i,
    // Current value
    output logic      [15:0] sp_o
);
    logic        init_r;
    logic [15:0] sp_r;

    // Strap top value is loaded on the first edge after release, not under reset
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            init_r <= 1'b1;
        else
            init_r <= 1'b0;
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            sp_r <= 16'h0000;
        else if (init_r)
            sp_r <= top_i;
        else if (push_i)
            sp_r <= sp_r - 16'h0002;
        else if (wr_lo_i)
            sp_r <= {sp_r[15:8], wdata_i};
        else if (wr_hi_i)
            sp_r <= {wdata_i, sp_r[7:0]};
    end

    assign sp_o = sp_r;
endmodule // stack_ptr_reg
`default_nettype wire

// >>> tb/mem_space_decoder_monitor.sv
// Port checker for the memory space decoder
`timescale 1ns/1ps
`default_nettype none
module mem_space_decoder_monitor
    import mem_space_pkg::*;
(
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire data_req_t   req_i,
    input wire logic        push_ret_i,
    input wire logic        flash_wr_i,
    input wire data_rgn_t   region_o,
    input wire logic        io_sel_o,
    input wire logic        sram_sel_o,
    input wire logic        wr_en_o,
    input wire logic        rd_en_o,
    input wire logic        op_illegal_o,
    input wire logic [7:0]  rdata_o,
    input wire logic [16:0] program_counter_o,
    input wire logic        flash_wr_en_o,
    input wire logic [15:0] stack_pointer_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    io_decode_a: assert property (req_i.op == OP_MEM_READ && req_i.addr <= 16'h0fff
        |=> io_sel_o && rd_en_o) else $error("io read not decoded");
    sram_write_a: assert property (req_i.op == OP_MEM_WRITE && req_i.addr == 16'h2000
        |=> sram_sel_o && wr_en_o) else $error("sram write not decoded");
    rsvd_quiet_a: assert property (region_o == RGN_RSVD |-> !wr_en_o && !rd_en_o)
        else $error("strobe in reserved space");
    port_range_a: assert property ((req_i.op == OP_PORT_READ || req_i.op == OP_PORT_WRITE)
        && req_i.addr > 16'h003f |=> op_illegal_o && !wr_en_o && !rd_en_o)
        else $error("port op out of range accepted");
    bit_range_a: assert property (req_i.op inside {OP_BIT_SET, OP_BIT_CLEAR, OP_BIT_TEST}
        && req_i.addr > 16'h001f |=> op_illegal_o ##0 !wr_en_o) else $error("bit op accepted");
    rdata_zero_a: assert property (!rd_en_o |=> rdata_o == 8'h00)
        else $error("read data without read");
    flash_gate_a: assert property (flash_wr_en_o |-> $past(flash_wr_i)
        && $past(program_counter_o) >= 17'h02000) else $error("flash write outside boot");
    pc_reset_a: assert property ($fell(rst_i) |-> program_counter_o == 17'h00000)
        else $error("pc not zero after reset");
    sp_push_a: assert property (push_ret_i |-> ##2 stack_pointer_o == $past(stack_pointer_o)
        - 16'h0002) else $error("push did not lower sp by two");
    cover property (req_i.op == OP_BIT_TEST);
    cover property (flash_wr_en_o);
    cover property (push_ret_i);
endmodule // mem_space_decoder_monitor
bind mem_space_decoder mem_space_decoder_monitor u_mon (.clk_i(clk_i), .rst_i(rst_i),
    .req_i(req_i), .push_ret_i(push_ret_i), .flash_wr_i(flash_wr_i), .region_o(region_o),
    .io_sel_o(io_sel_o), .sram_sel_o(sram_sel_o), .wr_en_o(wr_en_o), .rd_en_o(rd_en_o),
    .op_illegal_o(op_illegal_o), .rdata_o(rdata_o), .program_counter_o(program_counter_o),
    .flash_wr_en_o(flash_wr_en_o), .stack_pointer_o(stack_pointer_o));
`default_nettype wire

// >>> tb/mem_space_decoder_tb.sv
// Self-checking bench for the memory space decoder
`timescale 1ns/1ps
`default_nettype none
`include "mem_space_params.svh"
module mem_space_decoder_tb
    import mem_space_pkg::*;
;
    logic clk_i = 1'b0, rst_i = 1'b1, pc_load_i = 1'b0, pc_step_i = 1'b0, pc_step2_i = 1'b0;
    logic push_ret_i = 1'b0, flash_wr_i = 1'b0;
    logic [16:0] pc_target_i = '0, flash_addr_i = '0, program_counter_o;
    variant_t variant_i = VAR_128K;
    data_req_t req_i = '0;
    sec_lock_t app_lock_i = 4'hf, tbl_lock_i = 4'hf, boot_lock_i = 4'hf;
    data_rgn_t region_o, s_rgn;
    flash_sec_t fetch_sec_o;
    logic io_sel_o, ee_sel_o, sram_sel_o, wr_en_o, rd_en_o, op_illegal_o, skip_o;
    logic fetch_ok_o, flash_wr_en_o;
    logic [7:0] rdata_i, rdata_o;
    logic [15:0] stack_pointer_o;
    logic [5:0] s_st;
    int n_fail = 0, checks = 0;
    localparam logic [15:0] EE_END [4] = '{`EE_END_1K, `EE_END_1K, `EE_END_2K, `EE_END_2K};
    localparam logic [15:0] SR_END [4] = '{`SRAM_END_2K, `SRAM_END_4K, `SRAM_END_4K, `SRAM_END_8K};
    localparam logic [16:0] TBL [4] = '{`TBL_BASE_16, `TBL_BASE_32, `TBL_BASE_64, `TBL_BASE_128};
    localparam logic [16:0] BOOT [4] = '{`BOOT_BASE_16, `BOOT_BASE_32, `BOOT_BASE_64, `BOOT_BASE_128};
    localparam logic [16:0] BEND [4] = '{`BOOT_END_16, `BOOT_END_32, `BOOT_END_64, `BOOT_END_128};
    always #5 clk_i = ~clk_i;
    mem_space_decoder u_dut (.clk_i(clk_i), .rst_i(rst_i), .variant_i(variant_i), .req_i(req_i),
        .rdata_i(rdata_i), .pc_load_i(pc_load_i), .pc_target_i(pc_target_i), .pc_step_i(pc_step_i),
        .pc_step2_i(pc_step2_i), .push_ret_i(push_ret_i), .flash_wr_i(flash_wr_i),
        .flash_addr_i(flash_addr_i), .app_lock_i(app_lock_i), .tbl_lock_i(tbl_lock_i),
        .boot_lock_i(boot_lock_i), .region_o(region_o), .io_sel_o(io_sel_o), .ee_sel_o(ee_sel_o),
        .sram_sel_o(sram_sel_o), .wr_en_o(wr_en_o), .rd_en_o(rd_en_o), .op_illegal_o(op_illegal_o),
        .rdata_o(rdata_o), .skip_o(skip_o), .program_counter_o(program_counter_o),
        .fetch_sec_o(fetch_sec_o), .fetch_ok_o(fetch_ok_o), .flash_wr_en_o(flash_wr_en_o),
        .stack_pointer_o(stack_pointer_o));
    mem_target_model u_tgt (.clk_i(clk_i), .rst_i(rst_i), .rd_en_i(rd_en_o), .region_i(region_o),
        .rdata_o(rdata_i));
    // ------------------------------------------------------------
    // Bus tasks and scenarios
    // ------------------------------------------------------------
    task automatic chk(input logic [16:0] got, input logic [16:0] exp, input string what);
        checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("MISMATCH at %0t: %s got %0h exp %0h", $time, what, got, exp);
        end
    endtask
    task automatic end_sim;
        $display("Totals: checks=%0d n_fail=%0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // Variant strap is set while reset is held; it passes two flops on every edge and settles before release
    task automatic do_reset(input int v);
        @(posedge clk_i);
        rst_i <= 1'b1;
        variant_i <= variant_t'(v);
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        #1;
    endtask
    // Strobes are snapped one cycle after the request, read data after two
    task automatic access(input data_op_t op, input logic [15:0] a, input logic [2:0] b);
        @(posedge clk_i);
        req_i <= '{op, a, 8'h77, b};
        @(posedge clk_i);
        req_i <= '0;
        #1;
        s_rgn = region_o;
        s_st = {io_sel_o, ee_sel_o, sram_sel_o, wr_en_o, rd_en_o, op_illegal_o};
        @(posedge clk_i);
        #1;
    endtask
    task automatic set_pc(input logic [16:0] t);
        @(posedge clk_i);
        pc_load_i <= 1'b1;
        pc_target_i <= t;
        @(posedge clk_i);
        pc_load_i <= 1'b0;
        @(posedge clk_i);
        #1;
    endtask
    task automatic flash_write(input sec_lock_t lk);
        @(posedge clk_i);
        flash_wr_i <= 1'b1;
        flash_addr_i <= 17'h00010;
        app_lock_i <= lk;
        @(posedge clk_i);
        flash_wr_i <= 1'b0;
        app_lock_i <= 4'hf;
        #1;
    endtask
    task automatic t_data_map(input int v);
        logic [15:0] a [9];
        data_rgn_t r [9];
        a = '{16'h0000, 16'h0fff, 16'h1000, EE_END[v], EE_END[v] + 16'h1, 16'h2000, SR_END[v],
              SR_END[v] + 16'h1, 16'hffff};
        r = '{RGN_IO, RGN_IO, RGN_EE, RGN_EE, RGN_RSVD, RGN_SRAM, RGN_SRAM, RGN_RSVD, RGN_RSVD};
        for (int i = 0; i < 9; i++)
        begin
            access(OP_MEM_READ, a[i], 3'h0);
            chk(s_rgn, r[i], "region");
            chk(rdata_o, r[i] == RGN_IO ? 8'ha5 : r[i] == RGN_EE ? 8'h3c :
                r[i] == RGN_SRAM ? 8'h5a : 8'h00, "read data");
            access(OP_MEM_WRITE, a[i], 3'h0);
            chk(s_st[2], r[i] != RGN_RSVD, "write strobe");
        end
        $display("data map done, variant %0d", v);
    endtask
    task automatic t_flash(input int v);
        set_pc(TBL[v]);
        chk(fetch_sec_o, SEC_TABLE, "table section");
        chk(fetch_ok_o, 1'b1, "unlocked fetch");
        set_pc(BOOT[v] - 17'h1);
        flash_write(4'hf);
        chk(flash_wr_en_o, 1'b0, "write below boot");
        set_pc(BEND[v] + 17'h1);
        chk(fetch_sec_o, SEC_NONE, "past boot end");
        set_pc(BOOT[v]);
        chk(fetch_sec_o, SEC_BOOT, "boot section");
        flash_write(4'hf);
        chk(flash_wr_en_o, 1'b1, "write from boot");
        flash_write(4'h3);
        chk(flash_wr_en_o, 1'b0, "write locked");
        @(posedge clk_i);
        pc_step2_i <= 1'b1;
        @(posedge clk_i);
        pc_step2_i <= 1'b0;
        pc_step_i <= 1'b1;
        @(posedge clk_i);
        pc_step_i <= 1'b0;
        #1;
        chk(program_counter_o, BOOT[v] + 17'h3, "word steps");
        set_pc(17'h00000);
        flash_write(4'h0);
        chk(fetch_ok_o, 1'b0, "read locked fetch");
        $display("flash map done, variant %0d", v);
    endtask
    task automatic t_io_ops;
        access(OP_PORT_READ, 16'h003f, 3'h0);
        chk(s_st[1:0], 2'b10, "port read 3f");
        access(OP_PORT_WRITE, 16'h0040, 3'h0);
        chk(s_st[2:0], 3'b001, "port write 40");
        access(OP_BIT_SET, 16'h001f, 3'h2);
        chk(s_st[2:0], 3'b110, "bit set 1f");
        access(OP_BIT_CLEAR, 16'h0020, 3'h2);
        chk(s_st[2:0], 3'b001, "bit clear 20");
        access(OP_BIT_TEST, 16'h001f, 3'h0);
        chk(skip_o, 1'b1, "skip on set bit");
        access(OP_BIT_TEST, 16'h001f, 3'h1);
        chk(skip_o, 1'b0, "no skip on clear bit");
        access(OP_MEM_WRITE, 16'h0fff, 3'h0);
        chk(s_st[5:2], 4'b1001, "full address io write");
        $display("io ops done");
    endtask
    task automatic t_stack;
        @(posedge clk_i);
        push_ret_i <= 1'b1;
        @(posedge clk_i);
        push_ret_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        #1;
        chk(stack_pointer_o, `SRAM_END_8K - 16'h2, "push");
        access(OP_MEM_WRITE, `SP_LO_ADDR, 3'h0);
        access(OP_MEM_WRITE, `SP_HI_ADDR, 3'h0);
        repeat (2) @(posedge clk_i);
        #1;
        chk(stack_pointer_o, 16'h7777, "sp written as io");
        $display("stack done");
    endtask
    initial
    begin
        repeat (20000) @(posedge clk_i);
        n_fail++;
        $display("MISMATCH at %0t: run timed out", $time);
        end_sim();
    end
    initial
    begin
        for (int v = 0; v < 4; v++)
        begin
            do_reset(v);
            chk(program_counter_o, 17'h0, "pc after reset");
            chk(stack_pointer_o, SR_END[v], "sp after reset");
            t_data_map(v);
            t_flash(v);
        end
        t_io_ops();
        t_stack();
        end_sim();
    end
endmodule // mem_space_decoder_tb
`default_nettype wire

// >>> tb/mem_target_model.sv
// Behavioural data targets that answer decoder reads
`timescale 1ns/1ps
`default_nettype none
module mem_target_model
    import mem_space_pkg::*;
(
    input  wire logic      clk_i,
    input  wire logic      rst_i,
    input  wire logic      rd_en_i,
    input  wire data_rgn_t region_i,
    output logic [7:0]     rdata_o
);
    logic [7:0] last_r;
    // Idle cycles show a toggling byte so stale data never looks valid
    always_comb
    begin
        if (rd_en_i)
            rdata_o = (region_i == RGN_IO) ? 8'ha5 : (region_i == RGN_EE) ? 8'h3c : 8'h5a;
        else
            rdata_o = ~last_r;
    end
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            last_r <= 8'h00;
        else
            last_r <= rdata_o;
    end
endmodule // mem_target_model
`default_nettype wire
